// [verilog/gpcn_port.sv]
/*
 * Sixteen-pin digital port with open-drain, analog select, weak pulls,
 * change notification and clear/set/invert aliases on AXI4-Lite.
 * Assumes pins are synchronous to aclk and the master keeps one read
 * and one write outstanding at most.
 */
`timescale 1ns/100ps
module gpcn_port
   import gpcn_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe_n,
   output logic [PINS-1:0] analog_enable,
   output logic [PINS-1:0] weak_pullup_enable,
   output logic [PINS-1:0] weak_pulldown_enable,
   output logic change_irq
);
   logic [15:0] regs [NUM_REGS];
   logic [15:0] change_notify_status;
   logic [15:0] pin_q;
   logic [15:0] change;
   logic [15:0] next_status;
   logic [ADDR_W-1:0] waddr;
   logic [15:0] wd;
   logic [15:0] wmask;
   logic aw_held;
   logic w_held;
   logic do_write;
   logic ar_take;
   logic port_read;
   logic detect_on;
   logic [3:0] widx;
   logic [3:0] tgt;
   gpcn_op_t wop;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
      reg_ok = (a[7:4] < 4'(NUM_REGS)) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [15:0] apply_op(input logic [15:0] old,
      input gpcn_op_t op, input logic [15:0] d, input logic [15:0] m);
      logic [15:0] v;
      v = d & m;
      unique case (op)
         OP_WRITE: apply_op = (old & ~m) | v;
         OP_CLR: apply_op = old & ~v;
         OP_SET: apply_op = old | v;
         OP_INV: apply_op = old ^ v;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   assign do_write = aw_held && w_held && !bvalid;
   assign widx = waddr[7:4];
   assign wop = gpcn_op_t'(waddr[3:2]);
   // Port writes land in the latch.
   assign tgt = (widx == REG_PORT) ? REG_LATCH : widx;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         waddr <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         waddr <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_held <= 1'b0;
         wd <= ZERO_RST;
         wmask <= ZERO_RST;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held <= 1'b1;
         wd <= wdata[15:0];
         wmask <= {{8{wstrb[1]}}, {8{wstrb[0]}}};
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (!w_held && !bvalid) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= reg_ok(waddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Status is hardware owned and ignores writes; the aliases act on
   // the base register only.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs[i] <= ZERO_RST;
         end
         regs[REG_DIR] <= DIR_RST;
         regs[REG_ANALOG] <= ANALOG_RST;
      end else if (do_write && reg_ok(waddr) && widx != REG_NOTIFY_STAT) begin
         regs[tgt] <= apply_op(regs[tgt], wop, wd, wmask);
      end
   end

   // ----------------------------------------------------------------
   // Change notification
   // ----------------------------------------------------------------
   assign detect_on = regs[REG_NOTIFY_CTL][NOTIFY_ON_BIT];

   gpcn_change_detect u_detect (
      .aclk(aclk),
      .aresetn(aresetn),
      .detect_on(detect_on),
      .pins(pin_in),
      .change(change)
   );

   assign ar_take = arvalid && arready;
   assign port_read = ar_take && araddr[7:4] == REG_PORT
      && araddr[3:0] == 4'h0;
   // A change in the clearing cycle survives the clear.
   assign next_status = (change_notify_status & ~{16{port_read}})
      | change;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         change_notify_status <= ZERO_RST;
      end else begin
         change_notify_status <= next_status;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         change_irq <= 1'b0;
      end else begin
         change_irq <= detect_on
            && |(next_status & regs[REG_NOTIFY_EN]);
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= ZERO_RST;
      end else begin
         pin_q <= pin_in;
      end
   end

   // Alias reads return zero, a fixed choice for undefined data.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (ar_take) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= reg_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
         if (!reg_ok(araddr) || araddr[3:2] != 2'b00) begin
            rdata <= 32'h0000_0000;
         end else if (araddr[7:4] == REG_PORT) begin
            rdata <= {16'h0000, pin_q & ~regs[REG_ANALOG]};
         end else if (araddr[7:4] == REG_NOTIFY_STAT) begin
            rdata <= {16'h0000, change_notify_status};
         end else begin
            rdata <= {16'h0000, regs[araddr[7:4]]};
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // Analog select does not gate the driver, so a converter can sample
   // the driven level.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= ZERO_RST;
         pin_oe_n <= DIR_RST;
      end else begin
         pin_out <= regs[REG_LATCH] & ~regs[REG_OPEN_DRAIN];
         pin_oe_n <= regs[REG_DIR]
            | (regs[REG_OPEN_DRAIN] & regs[REG_LATCH]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog_enable <= ANALOG_RST;
         weak_pullup_enable <= ZERO_RST;
         weak_pulldown_enable <= ZERO_RST;
      end else begin
         analog_enable <= regs[REG_ANALOG];
         weak_pullup_enable <= regs[REG_PU];
         weak_pulldown_enable <= regs[REG_PD];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_read_base(logic [3:0] idx);
      ar_take && araddr == {idx, 4'h0};
   endsequence
   sequence s_write_alias(logic [1:0] op);
      do_write && reg_ok(waddr) && waddr[3:2] == op;
   endsequence

   property p_reset_dir;
      @(posedge aclk) !aresetn |=> regs[REG_DIR] == DIR_RST
         && pin_oe_n == DIR_RST;
   endproperty
   a_reset_dir: assert property (p_reset_dir)
      else $error("direction not all inputs after reset");
   property p_reset_analog;
      @(posedge aclk) !aresetn |=> regs[REG_ANALOG] == ANALOG_RST;
   endproperty
   a_reset_analog: assert property (p_reset_analog)
      else $error("analog select not all ones after reset");

   property p_input_dir;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (pin_oe_n & $past(regs[REG_DIR])) == $past(regs[REG_DIR]);
   endproperty
   a_input_dir: assert property (p_input_dir)
      else $error("input pin driven");

   property p_open_drain;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (pin_out & $past(regs[REG_OPEN_DRAIN])) == ZERO_RST;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open-drain pin driven high");

   property p_latch_read;
      @(posedge aclk) disable iff (!aresetn)
      s_read_base(REG_LATCH) |=> rvalid
         && rdata[15:0] == $past(regs[REG_LATCH]);
   endproperty
   a_latch_read: assert property (p_latch_read)
      else $error("latch read mismatch");

   property p_port_read;
      @(posedge aclk) disable iff (!aresetn)
      s_read_base(REG_PORT) |=> rvalid
         && rdata[15:0] == ($past(pin_q) & ~$past(regs[REG_ANALOG]));
   endproperty
   a_port_read: assert property (p_port_read)
      else $error("port read not masked pin levels");

   property p_alias_read;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && araddr[3:2] != 2'b00) |=> rdata == 32'h0000_0000;
   endproperty
   a_alias_read: assert property (p_alias_read)
      else $error("alias read not zero");

   property p_set_alias;
      @(posedge aclk) disable iff (!aresetn)
      (s_write_alias(2'b10) ##0 (tgt == REG_LATCH)) |=> regs[REG_LATCH]
         == ($past(regs[REG_LATCH]) | ($past(wd) & $past(wmask)));
   endproperty
   a_set_alias: assert property (p_set_alias)
      else $error("set alias changed wrong bits");

   property p_set_wins;
      @(posedge aclk) disable iff (!aresetn)
      change != ZERO_RST |=>
         (change_notify_status & $past(change)) == $past(change);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("change lost");
   property p_status_clear;
      @(posedge aclk) disable iff (!aresetn)
      (port_read && change == ZERO_RST) |=>
         change_notify_status == ZERO_RST;
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("port read did not clear status");

   property p_irq;
      @(posedge aclk) disable iff (!aresetn)
      (detect_on && !port_read
         && |(change_notify_status & regs[REG_NOTIFY_EN])) |=> change_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("change request missing");
endmodule

// [verilog/gpcn_pkg.sv]
/*
 * Constants, register map and types of the general purpose port with
 * change notification.
 * Assumes a 32-bit AXI4-Lite master and a 40 MHz clock.
 */
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package gpcn_pkg;
   localparam int PINS = 16;
   localparam int ADDR_W = 8;
   localparam int NUM_REGS = 10;

   // ----------------------------------------------------------------
   // Register indices, each base at index times 0x10.
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_DIR = 4'h0;
   localparam logic [3:0] REG_LATCH = 4'h1;
   localparam logic [3:0] REG_PORT = 4'h2;
   localparam logic [3:0] REG_OPEN_DRAIN = 4'h3;
   localparam logic [3:0] REG_ANALOG = 4'h4;
   localparam logic [3:0] REG_NOTIFY_CTL = 4'h5;
   localparam logic [3:0] REG_NOTIFY_EN = 4'h6;
   localparam logic [3:0] REG_NOTIFY_STAT = 4'h7;
   localparam logic [3:0] REG_PU = 4'h8;
   localparam logic [3:0] REG_PD = 4'h9;

   localparam logic [7:0] ALIAS_CLR = 8'h04;
   localparam logic [7:0] ALIAS_SET = 8'h08;
   localparam logic [7:0] ALIAS_INV = 8'h0C;

   localparam logic [15:0] DIR_RST = 16'hFFFF;
   localparam logic [15:0] ANALOG_RST = 16'hFFFF;
   localparam logic [15:0] ZERO_RST = 16'h0000;
   localparam int NOTIFY_ON_BIT = 15;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} gpcn_op_t;
endpackage

// [verilog/gpcn_change_detect.sv]
/*
 * Per-pin change-of-state detector.
 * Assumes pins are already synchronous to aclk.
 */
`timescale 1ns/100ps
module gpcn_change_detect
   import gpcn_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic detect_on,
   input wire logic [PINS-1:0] pins,
   output logic [PINS-1:0] change
);
   logic [PINS-1:0] last;

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   // The last level is tracked even while detection is off, so turning
   // it on does not report a stale difference as a change.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last <= ZERO_RST;
      end else begin
         last <= pins;
      end
   end

   // One clock only exists here; a sleeping core must keep aclk running
   // to this block for detection to continue.
   assign change = detect_on ? (pins ^ last) : ZERO_RST;

   property p_change_edge;
      @(posedge aclk) disable iff (!aresetn)
      (detect_on && pins != $past(pins)) |-> change != ZERO_RST;
   endproperty
   a_change_edge: assert property (p_change_edge)
      else $error("pin change not detected");
endmodule

// [testbench/gpcn_pin_model.sv]
/*
 * Board-side model of the sixteen port pins: port drive, external
 * resistors and the weak pulls resolved into the level each pin shows.
 * Assumes it is clocked by aclk, so pin changes stay synchronous to it.
 */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Pin resolution
// ----------------------------------------------------------------------
module gpcn_pin_model
   import gpcn_pkg::*;
(
   input wire logic aclk,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe_n,
   input wire logic [PINS-1:0] pull_up,
   input wire logic [PINS-1:0] pull_down,
   input wire logic [PINS-1:0] ext_en,
   input wire logic [PINS-1:0] ext_val,
   output logic [PINS-1:0] pin_in
);
   logic [PINS-1:0] float_q = 16'h5555;

   // A floating pin wanders, so it must never read as a steady level.
   always @(posedge aclk) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (!pin_oe_n[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pull_up[i] || pull_down[i]) begin
            pin_in[i] = pull_up[i];
         end else begin
            pin_in[i] = float_q[i];
         end
      end
   end
endmodule

// [testbench/gpcn_port_tb.sv]
/*
 * Self-checking bench for the port: register rows, then drive and
 * masking, change notification, refused accesses and a second reset.
 * Assumes the pin model beside it and an AXI4-Lite master of its own.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module gpcn_port_tb
   import gpcn_pkg::*;
;
   typedef struct packed {
      logic [7:0] wa;
      logic [15:0] wd;
      logic [7:0] ra;
      logic [15:0] ex;
   } gpcn_row_t;
   logic aclk;
   logic aresetn;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, change_irq;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [15:0] rd;
   logic [PINS-1:0] pin_in, pin_out, pin_oe_n, analog_enable, pu, pd;
   logic [PINS-1:0] ext_en, ext_val;
   int failures, checked;
   gpcn_row_t rows [10] = '{
      '{8'h10, 16'hA5A5, 8'h10, 16'hA5A5}, '{8'h20, 16'h1234, 8'h10, 16'h1234},
      '{8'h14, 16'h0204, 8'h10, 16'h1030}, '{8'h18, 16'h8001, 8'h10, 16'h9031},
      '{8'h1C, 16'hFFFF, 8'h10, 16'h6FCE}, '{8'h1C, 16'h0000, 8'h18, 16'h0000},
      '{8'h30, 16'h00F0, 8'h30, 16'h00F0}, '{8'h80, 16'h0F00, 8'h80, 16'h0F00},
      '{8'h90, 16'hF000, 8'h90, 16'hF000}, '{8'h70, 16'hFFFF, 8'h70, 16'h0000}};

   gpcn_port uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .analog_enable(analog_enable),
      .weak_pullup_enable(pu), .weak_pulldown_enable(pd),
      .change_irq(change_irq));
   gpcn_pin_model u_pins (.aclk(aclk), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pull_up(pu), .pull_down(pd), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in));

   // ------------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [15:0] d,
                            output logic [1:0] resp);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {16'h0000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [15:0] d,
                           output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata[15:0];
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic final_report();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // The whole run needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge aclk);
      failures++;
      final_report();
   end

   initial begin
      aresetn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      wdata = 32'h0000_0000;
      wstrb = 4'h3;
      ext_en = 16'h00F0;
      ext_val = 16'h00F0;
      failures = 0;
      checked = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         axi_write(rows[i].wa, rows[i].wd, rsp);
         `CHK(rsp, RESP_OKAY)
         axi_read(rows[i].ra, rd, rsp);
         `CHK(rd, rows[i].ex)
      end
      axi_write(8'h40, 16'h00FF, rsp);
      axi_write(8'h00, 16'hFF00, rsp);
      repeat (2) @(posedge aclk);
      `CHK(pin_oe_n, 16'hFFC0)
      `CHK(pin_out, 16'h6F0E)
      `CHK(analog_enable, 16'h00FF)
      `CHK({pu, pd}, 32'h0F00_F000)
      axi_read(8'h20, rd, rsp);
      `CHK(rd, 16'h0F00)
      axi_write(8'h40, 16'h0000, rsp);
      axi_write(8'h50, 16'h8000, rsp);
      axi_write(8'h60, 16'h0100, rsp);
      axi_read(8'h20, rd, rsp);
      `CHK(rd, 16'h0FCE)
      axi_read(8'h70, rd, rsp);
      `CHK(rd, 16'h0000)
      `CHK(change_irq, 1'b0)
      ext_en <= 16'h01F0;
      repeat (3) @(posedge aclk);
      `CHK(change_irq, 1'b1)
      axi_read(8'h70, rd, rsp);
      `CHK(rd, 16'h0100)
      axi_write(8'h64, 16'h0100, rsp);
      repeat (2) @(posedge aclk);
      `CHK(change_irq, 1'b0)
      axi_write(8'h68, 16'h0100, rsp);
      repeat (2) @(posedge aclk);
      `CHK(change_irq, 1'b1)
      axi_read(8'h20, rd, rsp);
      `CHK(rd, 16'h0ECE)
      repeat (2) @(posedge aclk);
      `CHK(change_irq, 1'b0)
      axi_read(8'h70, rd, rsp);
      `CHK(rd, 16'h0000)
      axi_write(8'hA0, 16'hFFFF, rsp);
      `CHK(rsp, RESP_SLVERR)
      axi_write(8'h11, 16'h0000, rsp);
      `CHK(rsp, RESP_SLVERR)
      axi_read(8'h10, rd, rsp);
      `CHK(rd, 16'h6FCE)
      axi_read(8'hA4, rd, rsp);
      `CHK({rsp, rd}, {RESP_SLVERR, 16'h0000})
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      `CHK(pin_oe_n, 16'hFFFF)
      `CHK(analog_enable, 16'hFFFF)
      aresetn <= 1'b1;
      axi_read(8'h00, rd, rsp);
      `CHK(rd, 16'hFFFF)
      axi_read(8'h40, rd, rsp);
      `CHK(rd, 16'hFFFF)
      axi_read(8'h10, rd, rsp);
      `CHK(rd, 16'h0000)
      axi_read(8'h20, rd, rsp);
      `CHK(rd, 16'h0000)
      `CHK(change_irq, 1'b0)
      final_report();
   end
endmodule
